/* File: design/e3_pmdl_message_transmitter.sv */
// E3 national-bit message transmitter with APB register slave
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// R1: Ninety-byte message store at one address
// R2: One message bit per outbound frame
// R3: Payload length any size up to 82
// R4: Flag, header, control, payload, FCS, flag order
// R5: Flag octet 0x7E delimits every frame
// R6: Idle sends continuous flag octets
// R7: Header octets 0x3C/0x3E and 0x01
// R8: Access point field is 001111
// R9: Terminal identifier bits are zero
// R10: Control octet is 0x03
// R11: First payload octet names message type
// R12: Other lengths allow any first octet
// R13: CRC-16 over header and payload inserted
// R14: Payload is exactly the stored octets
// R15: Load message fully before start command
// R16: Enable bit starts idle flag stream
// R17: Length bit selects 82 or 76 bytes
// R18: Source select 10 routes output to N bit; the code routes it only while the enable bit is set
// R19: Auto retransmit every one second
// R20: Zero inserted after five ones inside frame
module e3_pmdl_message_transmitter
#(
    parameter int unsigned RETX_CYCLES = e3_pmdl_pkg::RETX_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [17:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Outbound frame overhead
    input wire logic frame_tick_in,
    output logic nat_bit_out,
    output logic nat_route_out,
    output logic [1:0] national_bit_source_select_out
);
    import e3_pmdl_pkg::*;

    typedef struct packed {
        logic en;
        logic len82;
        logic auto_rt;
        logic any_len;
        logic [1:0] nsel;
        logic cr;
        logic ovf;
        logic go;
        logic [6:0] wr_cnt;
        logic [STORE_DEPTH-1:0][7:0] mem;
        tx_state_t st;
        logic [7:0] cur;
        logic [2:0] bit_idx;
        logic [2:0] ones;
        logic [6:0] byte_idx;
        logic [15:0] crc;
        logic nbit;
        logic [31:0] timer;
        logic [31:0] prdata;
    } state_t;

    state_t q;
    state_t d;
    logic mapped;
    logic [6:0] plen;
    logic [6:0] last_idx;
    logic start_frame;

    // Header octets then stored payload, by index within the frame body
    function automatic logic [7:0] body_octet(input state_t s, input logic [6:0] idx);
        logic [6:0] pidx;
        pidx = 7'(idx - HDR_LEN);
        if (idx == 7'd0) begin
            body_octet = {SAPI_VALUE, s.cr, 1'b0}; // [R7] [R8]
        end else if (idx == 7'd1) begin
            body_octet = TEI_OCTET; // [R9]
        end else if (idx == 7'd2) begin
            body_octet = CTRL_OCTET; // [R10]
        end else if (pidx < s.wr_cnt) begin
            body_octet = s.mem[pidx]; // [R14]
        end else begin
            body_octet = 8'h00;
        end
    endfunction

    assign mapped = (paddr_in == ADDR_E3_CFG) || (paddr_in == ADDR_LAPD_CFG) ||
                    (paddr_in == ADDR_STORE) || (paddr_in == ADDR_CMD);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = q.prdata;
    assign nat_bit_out = q.nbit;
    assign nat_route_out = q.en && (q.nsel == NSEL_LAPD); // [R18]
    assign national_bit_source_select_out = q.nsel;

    // Standard lengths unless any-length mode takes the store fill
    assign plen = q.any_len ? ((q.wr_cnt > LEN_ITU) ? LEN_ITU : q.wr_cnt) :
                  (q.len82 ? LEN_ITU : LEN_STD); // [R3] [R17] [R12]
    assign last_idx = 7'(HDR_LEN + plen - 7'd1);

    always_comb begin
        logic bitv;
        logic [15:0] crc_n;
        bitv = 1'b0;
        crc_n = q.crc;
        d = q;
        start_frame = 1'b0;

        // Register writes take effect in the access phase
        if (psel_in && penable_in && pwrite_in) begin
            case (paddr_in)
                ADDR_LAPD_CFG: begin
                    d.en = pwdata_in[CFG_EN_BIT];
                    d.len82 = pwdata_in[CFG_LEN_BIT];
                    d.auto_rt = pwdata_in[CFG_AUTO_BIT];
                    d.any_len = pwdata_in[CFG_ANY_BIT];
                end
                ADDR_E3_CFG: begin
                    d.nsel = pwdata_in[NSEL_LSB +: 2];
                end
                ADDR_STORE: begin
                    // Full store drops the octet rather than wrapping
                    if (q.wr_cnt < STORE_DEPTH_C) begin
                        d.mem[q.wr_cnt] = pwdata_in[7:0]; // [R1]
                        d.wr_cnt = 7'(q.wr_cnt + 7'd1);
                    end else begin
                        d.ovf = 1'b1;
                    end
                end
                ADDR_CMD: begin
                    d.cr = pwdata_in[CMD_CR_BIT];
                    if (pwdata_in[CMD_CLEAR_BIT]) begin
                        d.wr_cnt = 7'd0;
                        d.ovf = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data captured in the setup phase, so zero wait states
        if (psel_in && !penable_in) begin
            case (paddr_in)
                ADDR_LAPD_CFG: d.prdata = {24'h0, q.any_len, 3'h0, q.auto_rt, 1'b0,
                                           q.len82, q.en};
                ADDR_E3_CFG: d.prdata = {27'h0, q.nsel, 3'h0};
                ADDR_CMD: d.prdata = {17'h0, q.wr_cnt, 4'h0, q.cr, q.ovf, q.go,
                                      q.st != ST_FLAG};
                default: d.prdata = 32'h0;
            endcase
        end

        if (!q.en) begin
            // Disabled line idles at all ones
            d.st = ST_FLAG;
            d.cur = FLAG_OCTET;
            d.bit_idx = 3'd0;
            d.ones = 3'd0;
            d.nbit = 1'b1; // [R16]
        end else if (frame_tick_in) begin // [R2]
            if (q.ones == STUFF_RUN) begin
                d.nbit = 1'b0; // [R20]
                d.ones = 3'd0;
            end else begin
                bitv = q.cur[q.bit_idx];
                d.nbit = bitv;
                if (q.st == ST_BODY) begin
                    crc_n = {1'b0, q.crc[15:1]} ^ ((q.crc[0] ^ bitv) ? CRC_POLY_REV : 16'h0);
                    d.crc = crc_n; // [R13]
                end
                if ((q.st == ST_BODY) || (q.st == ST_FCS)) begin
                    d.ones = bitv ? 3'(q.ones + 3'd1) : 3'd0;
                end else begin
                    d.ones = 3'd0;
                end
                d.bit_idx = 3'(q.bit_idx + 3'd1);
                if (q.bit_idx == LAST_BIT) begin
                    case (q.st)
                        ST_FLAG: begin
                            // Flag just sent doubles as the opening flag
                            if (q.go) begin
                                start_frame = 1'b1; // [R15]
                                d.st = ST_BODY;
                                d.byte_idx = 7'd0;
                                d.cur = body_octet(q, 7'd0);
                                d.crc = CRC_INIT;
                            end else begin
                                d.cur = FLAG_OCTET; // [R6]
                            end
                        end
                        ST_BODY: begin
                            if (q.byte_idx == last_idx) begin
                                d.st = ST_FCS; // [R4]
                                d.byte_idx = 7'd0;
                                d.cur = ~crc_n[15:8]; // [R13]
                            end else begin
                                d.byte_idx = 7'(q.byte_idx + 7'd1);
                                d.cur = body_octet(q, 7'(q.byte_idx + 7'd1)); // [R11]
                            end
                        end
                        ST_FCS: begin
                            if (q.byte_idx == 7'd0) begin
                                d.byte_idx = 7'd1;
                                d.cur = ~q.crc[7:0];
                            end else begin
                                d.st = ST_CLOSE;
                                d.cur = FLAG_OCTET; // [R5]
                            end
                        end
                        ST_CLOSE: begin
                            d.st = ST_FLAG;
                            d.cur = FLAG_OCTET;
                        end
                        default: begin
                            d.st = ST_FLAG;
                            d.cur = FLAG_OCTET;
                        end
                    endcase
                end
            end
        end

        // Retransmit timer runs free once armed
        if (!q.en || !q.auto_rt) begin
            d.timer = 32'h0;
        end else if (q.timer >= RETX_CYCLES - 1) begin
            d.timer = 32'h0;
        end else begin
            d.timer = q.timer + 32'h1;
        end

        // A new request in the accept cycle keeps the request pending
        if (start_frame) begin
            d.go = 1'b0;
        end
        if (psel_in && penable_in && pwrite_in && (paddr_in == ADDR_CMD) &&
            pwdata_in[CMD_START_BIT]) begin
            d.go = 1'b1;
        end
        if (q.en && q.auto_rt && (q.timer >= RETX_CYCLES - 1)) begin
            d.go = 1'b1; // [R19]
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '0;
            q.cur <= FLAG_OCTET;
            q.nbit <= 1'b1;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    store_cap_a: assert property (q.wr_cnt <= STORE_DEPTH_C) // [R1]
        else $error("message store count beyond depth");
    store_write_a: assert property (psel_in && penable_in && pwrite_in &&
        paddr_in == ADDR_STORE && q.wr_cnt < STORE_DEPTH_C |=>
        q.wr_cnt == $past(q.wr_cnt) + 7'd1 && q.mem[$past(q.wr_cnt)] == $past(pwdata_in[7:0]))
        else $error("store write lost"); // [R14]
    bit_hold_a: assert property (q.en && !frame_tick_in |=> $stable(q.nbit)) // [R2]
        else $error("national bit changed without frame tick");
    idle_flag_a: assert property (q.st == ST_FLAG && q.en |-> q.cur == FLAG_OCTET) // [R6]
        else $error("idle stream not flag octets");
    close_flag_a: assert property (q.st == ST_FCS ##1 q.st == ST_CLOSE |-> // [R5]
        q.cur == FLAG_OCTET) else $error("closing octet is not a flag");
    stuff_zero_a: assert property (q.en && frame_tick_in && q.ones == STUFF_RUN |=> // [R20]
        !q.nbit && q.ones == 3'd0) else $error("no zero after five ones");
    disabled_a: assert property (!q.en |=> q.nbit) // [R16]
        else $error("disabled line not idle high");
    len_sel_a: assert property (!q.any_len |-> plen == (q.len82 ? LEN_ITU : LEN_STD))
        else $error("payload length does not follow select"); // [R17]
    len_max_a: assert property (plen <= LEN_ITU) // [R3]
        else $error("payload longer than 82");
    crc_seed_a: assert property (start_frame |=> q.st == ST_BODY && q.crc == CRC_INIT &&
        q.cur == {SAPI_VALUE, $past(q.cr), 1'b0}) else $error("frame start wrong"); // [R13]
    fcs_order_a: assert property (q.st == ST_FCS |=> q.st == ST_FCS || q.st == ST_CLOSE)
        else $error("check octets not followed by close"); // [R4]
    retx_a: assert property (q.en && q.auto_rt && q.timer >= RETX_CYCLES - 1 |=> q.go)
        else $error("auto retransmit not requested"); // [R19]
    route_a: assert property (q.nsel == NSEL_LAPD && q.en |-> nat_route_out) // [R18]
        else $error("national bit not routed");
    frame_start_c: cover property (start_frame);
    stuff_c: cover property (frame_tick_in && q.ones == STUFF_RUN && q.en);
    retx_c: cover property (q.auto_rt && q.timer >= RETX_CYCLES - 1);
    overflow_c: cover property (q.ovf);
endmodule

/* File: design/e3_pmdl_pkg.sv */
// Constants and types for the E3 path maintenance message transmitter
package e3_pmdl_pkg;
    // Clock and timing
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned RETX_PERIOD_MS = 1000;
    localparam int unsigned RETX_CYCLES_DEF = RETX_PERIOD_MS * 1000 * CLK_MHZ;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_E3_CFG = 16'h1130;
    localparam logic [15:0] IDX_LAPD_CFG = 16'h1133;
    localparam logic [15:0] IDX_STORE = 16'h11b0;
    localparam logic [15:0] IDX_CMD = 16'h11b4;
    localparam logic [17:0] ADDR_E3_CFG = {IDX_E3_CFG, 2'b00};
    localparam logic [17:0] ADDR_LAPD_CFG = {IDX_LAPD_CFG, 2'b00};
    localparam logic [17:0] ADDR_STORE = {IDX_STORE, 2'b00};
    localparam logic [17:0] ADDR_CMD = {IDX_CMD, 2'b00};

    // Field positions
    localparam int unsigned CFG_EN_BIT = 0;
    localparam int unsigned CFG_LEN_BIT = 1;
    localparam int unsigned CFG_AUTO_BIT = 3;
    localparam int unsigned CFG_ANY_BIT = 7;
    localparam int unsigned NSEL_LSB = 3;
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_CLEAR_BIT = 1;
    localparam int unsigned CMD_CR_BIT = 2;
    localparam int unsigned STAT_CNT_LSB = 8;
    localparam logic [1:0] NSEL_LAPD = 2'b10;

    // Frame layout
    localparam logic [7:0] FLAG_OCTET = 8'h7e;
    localparam logic [5:0] SAPI_VALUE = 6'h0f;
    localparam logic [7:0] TEI_OCTET = 8'h01;
    localparam logic [7:0] CTRL_OCTET = 8'h03;
    localparam int unsigned STORE_DEPTH = 90;
    localparam logic [6:0] STORE_DEPTH_C = 7'd90;
    localparam logic [6:0] HDR_LEN = 7'd3;
    localparam logic [6:0] LEN_STD = 7'd76;
    localparam logic [6:0] LEN_ITU = 7'd82;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [2:0] STUFF_RUN = 3'd5;
    localparam logic [2:0] LAST_BIT = 3'd7;

    typedef enum logic [1:0] {
        ST_FLAG = 2'b00,
        ST_BODY = 2'b01,
        ST_FCS = 2'b10,
        ST_CLOSE = 2'b11
    } tx_state_t;
endpackage

/* File: test/pmdl_frame_receiver.sv */
// Far-end receive model that rebuilds message frames from the national bit
`timescale 1ns/1ps
module pmdl_frame_receiver (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // National bit stream
    input wire logic tick_in,
    input wire logic bit_in,
    // Counts
    output int frame_cnt_out,
    output int flag_cnt_out
);
    logic [7:0] octet_q [0:99];
    int len_q;
    logic [7:0] raw_q;
    int ones_q;
    logic q[$];
    // Bit of the previous slot still stands at the tick edge
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            raw_q = 8'h00;
            ones_q = 0;
            len_q = 0;
            frame_cnt_out = 0;
            flag_cnt_out = 0;
            q.delete();
        end else if (tick_in) begin
            raw_q = {bit_in, raw_q[7:1]};
            if (raw_q == 8'h7e) begin
                flag_cnt_out++;
                // Aborted or ragged frames are dropped silently
                if (q.size() > 7 && (q.size() - 7) % 8 == 0) begin
                    len_q = (q.size() - 7) / 8;
                    for (int i = 0; i < len_q && i < 100; i++)
                        for (int b = 0; b < 8; b++)
                            octet_q[i][b] = q[i * 8 + b];
                    frame_cnt_out++;
                end
                q.delete();
            end else if (!(ones_q == 5 && !bit_in)) begin
                q.push_back(bit_in);
            end
            ones_q = bit_in ? ones_q + 1 : 0;
            // Seven ones abort any partial frame, as on an idle line
            if (ones_q > 6)
                q.delete();
        end
    end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the E3 national-bit message transmitter
`timescale 1ns/1ps
module tb;
    import e3_pmdl_pkg::*;
    logic mclk_in;
    logic nrst_in;
    logic psel_in, penable_in, pwrite_in, frame_tick_in;
    logic [17:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, perr, nat_bit_out, nat_route_out;
    logic [1:0] national_bit_source_select_out;
    logic [7:0] types [4] = '{8'h38, 8'h34, 8'h32, 8'h3f};
    int err_total, num_checks, frames, flags, rx_frames, rx_flags;
    int tick_cnt = 0;

    e3_pmdl_message_transmitter #(.RETX_CYCLES(2000)) DUT (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .frame_tick_in(frame_tick_in),
        .nat_bit_out(nat_bit_out), .nat_route_out(nat_route_out),
        .national_bit_source_select_out(national_bit_source_select_out));
    pmdl_frame_receiver rx (
        .clk_in(mclk_in), .nrst_in(nrst_in), .tick_in(frame_tick_in),
        .bit_in(nat_bit_out), .frame_cnt_out(rx_frames), .flag_cnt_out(rx_flags));

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    // One outbound frame slot every four clocks keeps runs short
    always @(posedge mclk_in) begin
        tick_cnt <= (tick_cnt == 3) ? 0 : tick_cnt + 1;
        frame_tick_in <= (tick_cnt == 3);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        check(pready_out, 1'b1);
        rd = prdata_out;
        perr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wait_frames(input int k);
        int t;
        t = 0;
        frames = frames + k;
        while (rx_frames < frames && t < 20000) begin
            @(posedge mclk_in);
            t++;
        end
        check(rx_frames >= frames, 1);
    endtask
    task automatic send_msg(input logic [7:0] typ, input int len, input logic [31:0] cfg,
                            input logic cr);
        logic [7:0] exp [$];
        logic [15:0] crc;
        apb(1'b1, ADDR_LAPD_CFG, cfg);
        apb(1'b1, ADDR_CMD, 32'h2);
        exp = '{{6'b001111, cr, 1'b0}, 8'h01, 8'h03};
        // Runs of 0xff force zero insertion inside the frame
        for (int k = 0; k < len; k++) begin
            exp.push_back(k == 0 ? typ : (k % 7 == 0 ? 8'hff : k[7:0] ^ typ));
            apb(1'b1, ADDR_STORE, {24'h0, exp[k + 3]});
        end
        crc = 16'hffff;
        foreach (exp[i]) begin
            crc = crc ^ {8'h00, exp[i]};
            for (int b = 0; b < 8; b++)
                crc = crc[0] ? (crc >> 1) ^ 16'h8408 : crc >> 1;
        end
        crc = ~crc;
        exp.push_back(crc[15:8]);
        exp.push_back(crc[7:0]);
        apb(1'b1, ADDR_CMD, {29'h0, cr, 2'b01});
        apb(1'b0, ADDR_CMD, 32'h0);
        check({31'h0, rd[1] | rd[0]}, 32'h1);
        wait_frames(1);
        check(rx.len_q, exp.size());
        foreach (exp[i]) check(rx.octet_q[i], exp[i]);
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk_in);
        // Timeout counts as one mismatch
        check(32'h0, 32'h1);
        give_verdict();
    end
    initial begin
        {nrst_in, psel_in, penable_in, pwrite_in} = 4'h0;
        paddr_in = 18'h00000;
        pwdata_in = 32'h0;
        {err_total, num_checks, frames} = {32'd0, 32'd0, 32'd0};
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        check(nat_bit_out, 1);
        check(nat_route_out, 0);
        apb(1'b0, ADDR_CMD, 32'h0);
        check(rd, 0);
        apb(1'b0, 18'h00010, 32'h0);
        check({perr, rd[30:0]}, 32'h80000000);
        $display("Test reset and decode done");
        apb(1'b1, ADDR_E3_CFG, 32'h10);
        apb(1'b1, ADDR_LAPD_CFG, 32'h1);
        @(posedge mclk_in);
        check(national_bit_source_select_out, 2'b10);
        check(nat_route_out, 1);
        apb(1'b0, ADDR_E3_CFG, 32'h0);
        check(rd, 32'h10);
        apb(1'b0, ADDR_LAPD_CFG, 32'h0);
        check(rd, 32'h1);
        flags = rx_flags;
        repeat (400) @(posedge mclk_in);
        check(rx_flags - flags >= 10, 1);
        check(rx_frames, 0);
        $display("Test idle flags done");
        apb(1'b1, ADDR_CMD, 32'h2);
        repeat (91) apb(1'b1, ADDR_STORE, 32'h55);
        apb(1'b0, ADDR_CMD, 32'h0);
        check({rd[14:8], rd[2]}, {7'd90, 1'b1});
        $display("Test store overflow done");
        for (int t = 0; t < 4; t++) begin
            send_msg(types[t], t == 3 ? 82 : 76, t == 3 ? 32'h3 : 32'h1, 1'b0);
            $display("Test message type %h done", types[t]);
        end
        send_msg(8'h5a, 5, 32'h81, 1'b1);
        $display("Test short message done");
        apb(1'b1, ADDR_LAPD_CFG, 32'h89);
        wait_frames(2);
        check(rx.len_q, 10);
        $display("Test auto repeat done");
        apb(1'b1, ADDR_LAPD_CFG, 32'h0);
        repeat (10) @(posedge mclk_in);
        check({nat_bit_out, nat_route_out}, 2'b10);
        $display("Test disable done");
        give_verdict();
    end
endmodule
